/* common/msa_defs.svh */
`ifndef MSA_DEFS_SVH
`define MSA_DEFS_SVH

// Transmit FIFO geometry and thresholds.
`define MSA_TX_DEPTH 2048
`define MSA_TX_AW 11
`define MSA_TX_CW 12
`define MSA_TX_WW 73
`define MSA_TX_READY_MAX 12'h380
`define MSA_TX_START_LO 2
`define MSA_TX_START_HI 10

// Receive FIFO geometry and thresholds.
`define MSA_RX_DEPTH 4096
`define MSA_RX_AW 12
`define MSA_RX_CW 13
`define MSA_RX_WW 74
`define MSA_RX_READY_LIMIT 13'h0B80
`define MSA_PKT_CW 13

// Field positions inside a FIFO word.
`define MSA_KEEP_LSB 64
`define MSA_LAST_BIT 72
`define MSA_USER_BIT 73

`endif

/* common/msa_pkg.sv */
package msa_pkg;

  // Transmit switch packet state.
  typedef enum logic [0:0] {
    MSA_SW_IDLE = 1'b0,
    MSA_SW_BUSY = 1'b1
  } msa_sw_state_t;

endpackage : msa_pkg

/* core/msa_stream_adapter.sv */
// What this block does
// - Transmit FIFO holds 2048 words and shows its head word before popping.
// - Transmit input ready rises only with at most 896 stored, previous packet done.
// - Each valid-ready input beat writes data, keep and last as one 73-bit word.
// - After accepting a last input beat, transmit input ready drops.
// - With enough free space, transmit input ready returns the next cycle.
// - New MAC packet starts when count bits 10:2 are nonzero and tvalid low.
// - Transmit FIFO pops at packet start, whatever tready is, and on accepted non-last MAC beats.
// - While MAC tvalid is high and tready is low, all outputs toward the MAC hold.
// - After an accepted tlast, tvalid drops and FIFO level is checked again.
// - Receive FIFO holds 4096 words, room for several packets.
// - Receive tready rises only when count below 2944 and no packet in progress.
// - Each received beat writes data, keep, last and user as a 74-bit word.
// - In-progress flag sets after a first beat and clears after the final beat.
// - On a final beat with count 2944 or more, receive tready drops.
// - Stored packet count rises by one when a word with bit 72 is written.
// - Beats offered while receive tready is low are never written.
// - Receive tready returns once idle and free space is enough again.
// - Downstream forwarding starts only when the stored packet count is nonzero.
// - Downstream valid stays high without gaps over one packet, fed from FIFO head.
// - Pop at packet start and on each non-last downstream handshake; after last, valid drops and count decrements.
// - Switch keeps its channel when both request idle, alternates after a packet if the other channel requests.
// - On stall the switch holds outputs, drops source ready, parks data in a latch.
`timescale 1ns/1ps
`include "msa_defs.svh"

module msa_stream_adapter
  import msa_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_switch_src0_valid,
  input wire logic [63:0] i_switch_src0_word,
  input wire logic [7:0] i_switch_src0_byte_en,
  input wire logic i_switch_src0_end,
  output logic o_switch_src0_ready,
  input wire logic i_switch_src1_valid,
  input wire logic [63:0] i_switch_src1_word,
  input wire logic [7:0] i_switch_src1_byte_en,
  input wire logic i_switch_src1_end,
  output logic o_switch_src1_ready,
  output logic o_tx_tvalid,
  input wire logic i_tx_tready,
  output logic [63:0] o_tx_tdata,
  output logic [7:0] o_tx_tkeep,
  output logic o_tx_tlast,
  input wire logic i_rx_tvalid,
  output logic o_rx_tready,
  input wire logic [63:0] i_rx_tdata,
  input wire logic [7:0] i_rx_tkeep,
  input wire logic i_rx_tlast,
  input wire logic i_rx_tuser,
  output logic o_down_valid,
  input wire logic i_down_ready,
  output logic [63:0] o_down_word,
  output logic [7:0] o_down_byte_en,
  output logic o_down_end,
  output logic o_down_user_flag,
  output logic o_rx_in_progress,
  output logic [`MSA_PKT_CW-1:0] o_stored_packet_count
);

  ////////////////////////////////////////////////////////////////////////////
  // Transmit switch.

  msa_sw_state_t sw_state_q;
  logic active_channel_select_q;
  logic [1:0] src_ready_q;
  logic [72:0] stall_hold_latch_q;
  logic latch_full_q;
  logic [72:0] tx_in_q;
  logic tx_in_valid_q;
  logic tx_in_ready_q;
  logic sel_valid;
  logic [72:0] sel_word;
  logic src_take;
  logic out_move;
  logic take_end;

  // Pick the beat of the active channel, packed as end, keep, data.
  assign sel_valid = active_channel_select_q ? i_switch_src1_valid
                                             : i_switch_src0_valid;
  assign sel_word = active_channel_select_q ?
    {i_switch_src1_end, i_switch_src1_byte_en, i_switch_src1_word} :
    {i_switch_src0_end, i_switch_src0_byte_en, i_switch_src0_word};
  assign src_take = sel_valid && src_ready_q[active_channel_select_q];
  assign take_end = src_take && sel_word[`MSA_LAST_BIT];
  // The output stage may advance when empty or when the FIFO side takes it.
  assign out_move = !tx_in_valid_q || tx_in_ready_q;

  // Channel choice only moves between packets, so a packet never interleaves.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sw_state_q <= MSA_SW_IDLE;
      active_channel_select_q <= 1'b0;
    end else if (sw_state_q == MSA_SW_IDLE) begin
      case ({i_switch_src1_valid, i_switch_src0_valid})
        2'b01: begin
          active_channel_select_q <= 1'b0;
          sw_state_q <= MSA_SW_BUSY;
        end
        2'b10: begin
          active_channel_select_q <= 1'b1;
          sw_state_q <= MSA_SW_BUSY;
        end
        2'b11: begin
          sw_state_q <= MSA_SW_BUSY;
        end
        default: begin
          sw_state_q <= MSA_SW_IDLE;
        end
      endcase
    end else if (take_end) begin
      sw_state_q <= MSA_SW_IDLE;
      if (active_channel_select_q ? i_switch_src0_valid
                                  : i_switch_src1_valid) begin
        active_channel_select_q <= !active_channel_select_q;
      end
    end
  end

  // Source ready is high only while busy with room in the latch.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      src_ready_q <= 2'h0;
    end else begin
      src_ready_q <= 2'h0;
      if (sw_state_q == MSA_SW_BUSY && !take_end) begin
        if (!(src_take && !out_move) && !(latch_full_q && !out_move)) begin
          src_ready_q[active_channel_select_q] <= 1'b1;
        end
      end
    end
  end

  // A beat taken while the output stage is stuck waits in the latch.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      stall_hold_latch_q <= 73'h0;
      latch_full_q <= 1'b0;
      tx_in_q <= 73'h0;
      tx_in_valid_q <= 1'b0;
    end else if (out_move) begin
      if (latch_full_q) begin
        tx_in_q <= stall_hold_latch_q;
        tx_in_valid_q <= 1'b1;
        latch_full_q <= 1'b0;
      end else if (src_take) begin
        tx_in_q <= sel_word;
        tx_in_valid_q <= 1'b1;
      end else begin
        tx_in_valid_q <= 1'b0;
      end
    end else if (src_take) begin
      stall_hold_latch_q <= sel_word;
      latch_full_q <= 1'b1;
    end
  end

  assign o_switch_src0_ready = src_ready_q[0];
  assign o_switch_src1_ready = src_ready_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO and its input side.

  logic [`MSA_TX_WW-1:0] tx_mem [0:`MSA_TX_DEPTH-1];
  logic [`MSA_TX_AW-1:0] tx_wr_ptr_q;
  logic [`MSA_TX_AW-1:0] tx_rd_ptr_q;
  logic [`MSA_TX_CW-1:0] tx_fill_count_q;
  logic tx_write_strobe;
  logic tx_pop_strobe;
  logic tx_load;

  // A write happens on every input handshake; full cannot occur by the gate.
  assign tx_write_strobe = tx_in_valid_q && tx_in_ready_q;

  always_ff @(posedge i_clock) begin
    if (tx_write_strobe) begin
      tx_mem[tx_wr_ptr_q] <= tx_in_q;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_wr_ptr_q <= '0;
      tx_rd_ptr_q <= '0;
      tx_fill_count_q <= '0;
    end else begin
      if (tx_write_strobe) begin
        tx_wr_ptr_q <= tx_wr_ptr_q + 1'b1;
      end
      if (tx_pop_strobe) begin
        tx_rd_ptr_q <= tx_rd_ptr_q + 1'b1;
      end
      case ({tx_write_strobe, tx_pop_strobe})
        2'b10: tx_fill_count_q <= tx_fill_count_q + 1'b1;
        2'b01: tx_fill_count_q <= tx_fill_count_q - 1'b1;
        default: tx_fill_count_q <= tx_fill_count_q;
      endcase
    end
  end

  // Ready stays up through a packet and drops for one check after its end.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_in_ready_q <= 1'b0;
    end else if (tx_write_strobe && tx_in_q[`MSA_LAST_BIT]) begin
      tx_in_ready_q <= 1'b0;
    end else if (!tx_in_ready_q) begin
      tx_in_ready_q <= (tx_fill_count_q <= `MSA_TX_READY_MAX);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit output toward the MAC.

  logic tx_valid_q;
  logic [72:0] tx_out_q;
  logic tx_empty;

  assign tx_empty = (tx_fill_count_q == '0);
  // The head word moves into the output flops at packet start and on each
  // accepted non-last beat, so the FIFO read side advances at packet start and on a handshake.
  assign tx_load = (!tx_valid_q &&
    (tx_fill_count_q[`MSA_TX_START_HI:`MSA_TX_START_LO] != '0)) ||
    (tx_valid_q && i_tx_tready && !tx_out_q[`MSA_LAST_BIT] && !tx_empty);
  assign tx_pop_strobe = tx_load;

  // A mid-packet underrun leaves a gap; the MAC side tolerates pauses.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_valid_q <= 1'b0;
      tx_out_q <= 73'h0;
    end else if (tx_load) begin
      tx_valid_q <= 1'b1;
      tx_out_q <= tx_mem[tx_rd_ptr_q];
    end else if (tx_valid_q && i_tx_tready) begin
      tx_valid_q <= 1'b0;
    end
  end

  assign o_tx_tvalid = tx_valid_q;
  assign o_tx_tdata = tx_out_q[63:0];
  assign o_tx_tkeep = tx_out_q[`MSA_LAST_BIT-1:`MSA_KEEP_LSB];
  assign o_tx_tlast = tx_out_q[`MSA_LAST_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Receive FIFO and its MAC side.

  logic [`MSA_RX_WW-1:0] rx_mem [0:`MSA_RX_DEPTH-1];
  logic [`MSA_RX_AW-1:0] rx_wr_ptr_q;
  logic [`MSA_RX_AW-1:0] rx_rd_ptr_q;
  logic [`MSA_RX_CW-1:0] rx_fill_count_q;
  logic rx_tready_q;
  logic rx_in_progress_q;
  logic [`MSA_PKT_CW-1:0] stored_packet_count_q;
  logic rx_write_strobe;
  logic rx_pop_strobe;
  logic [73:0] rx_word;
  logic rx_room;
  logic pkt_done;

  // Beats offered while tready is low are not handshakes and never land.
  assign rx_write_strobe = i_rx_tvalid && rx_tready_q;
  assign rx_word = {i_rx_tuser, i_rx_tlast, i_rx_tkeep, i_rx_tdata};
  assign rx_room = (rx_fill_count_q < `MSA_RX_READY_LIMIT);

  always_ff @(posedge i_clock) begin
    if (rx_write_strobe) begin
      rx_mem[rx_wr_ptr_q] <= rx_word;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_wr_ptr_q <= '0;
      rx_rd_ptr_q <= '0;
      rx_fill_count_q <= '0;
    end else begin
      if (rx_write_strobe) begin
        rx_wr_ptr_q <= rx_wr_ptr_q + 1'b1;
      end
      if (rx_pop_strobe) begin
        rx_rd_ptr_q <= rx_rd_ptr_q + 1'b1;
      end
      case ({rx_write_strobe, rx_pop_strobe})
        2'b10: rx_fill_count_q <= rx_fill_count_q + 1'b1;
        2'b01: rx_fill_count_q <= rx_fill_count_q - 1'b1;
        default: rx_fill_count_q <= rx_fill_count_q;
      endcase
    end
  end

  // Busy from the first beat until the final beat is stored.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_in_progress_q <= 1'b0;
    end else if (rx_write_strobe) begin
      rx_in_progress_q <= !i_rx_tlast;
    end
  end

  // Ready only pauses at a packet boundary, never inside a packet.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_tready_q <= 1'b0;
    end else if (!rx_tready_q) begin
      rx_tready_q <= !rx_in_progress_q && rx_room;
    end else if (rx_write_strobe && i_rx_tlast && !rx_room) begin
      rx_tready_q <= 1'b0;
    end
  end

  assign o_rx_tready = rx_tready_q;
  assign o_rx_in_progress = rx_in_progress_q;

  ////////////////////////////////////////////////////////////////////////////
  // Stored packet count and downstream forwarding.

  logic down_valid_q;
  logic [73:0] down_q;
  logic down_load;

  // Only complete packets are counted, so a started packet never starves.
  assign pkt_done = down_valid_q && i_down_ready && down_q[`MSA_LAST_BIT];
  assign down_load = (!down_valid_q && stored_packet_count_q != '0) ||
    (down_valid_q && i_down_ready && !down_q[`MSA_LAST_BIT]);
  assign rx_pop_strobe = down_load;

  // Increment and decrement in one cycle cancel, so no packet is lost.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      stored_packet_count_q <= '0;
    end else begin
      case ({rx_write_strobe && i_rx_tlast, pkt_done})
        2'b10: stored_packet_count_q <= stored_packet_count_q + 1'b1;
        2'b01: stored_packet_count_q <= stored_packet_count_q - 1'b1;
        default: stored_packet_count_q <= stored_packet_count_q;
      endcase
    end
  end

  // The whole packet is already stored, so each beat has a successor.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      down_valid_q <= 1'b0;
      down_q <= 74'h0;
    end else if (down_load) begin
      down_valid_q <= 1'b1;
      down_q <= rx_mem[rx_rd_ptr_q];
    end else if (pkt_done) begin
      down_valid_q <= 1'b0;
    end
  end

  assign o_down_valid = down_valid_q;
  assign o_down_word = down_q[63:0];
  assign o_down_byte_en = down_q[`MSA_LAST_BIT-1:`MSA_KEEP_LSB];
  assign o_down_end = down_q[`MSA_LAST_BIT];
  assign o_down_user_flag = down_q[`MSA_USER_BIT];
  assign o_stored_packet_count = stored_packet_count_q;

endmodule : msa_stream_adapter

/* test/msa_check_sva.sv */
`timescale 1ns/1ps
`include "msa_defs.svh"

module msa_check_sva (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_switch_src0_valid,
  input wire logic i_switch_src0_end,
  input wire logic o_switch_src0_ready,
  input wire logic o_tx_tvalid,
  input wire logic i_tx_tready,
  input wire logic [63:0] o_tx_tdata,
  input wire logic o_tx_tlast,
  input wire logic i_rx_tvalid,
  input wire logic o_rx_tready,
  input wire logic i_rx_tlast,
  input wire logic o_down_valid,
  input wire logic i_down_ready,
  input wire logic o_down_end,
  input wire logic o_rx_in_progress,
  input wire logic [`MSA_PKT_CW-1:0] o_stored_packet_count
);
  // Handshakes; both packet ends at once leave the count alone.
  wire rx_take = i_rx_tvalid && o_rx_tready;
  wire rx_end = rx_take && i_rx_tlast;
  wire dn_end = o_down_valid && i_down_ready && o_down_end;
  wire src_end = i_switch_src0_valid && o_switch_src0_ready &&
    i_switch_src0_end;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  sequence rx_only_s;
    rx_end && !dn_end;
  endsequence
  sequence dn_only_s;
    dn_end && !rx_end;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  tx_hold_a: assert property (
    o_tx_tvalid && !i_tx_tready |=> $stable({o_tx_tvalid, o_tx_tdata,
    o_tx_tlast})) else $error("tx output moved in a stall");
  tx_gap_a: assert property (
    o_tx_tvalid && i_tx_tready && o_tx_tlast |=> !o_tx_tvalid)
    else $error("tx valid stayed after last");
  src_pause_a: assert property (
    src_end |=> !o_switch_src0_ready) else $error("src ready after end");
  rx_arm_a: assert property (
    $rose(o_rx_tready) |-> !$past(o_rx_in_progress))
    else $error("rx ready rose mid packet");
  rx_busy_a: assert property (
    rx_take |=> o_rx_in_progress == !$past(i_rx_tlast))
    else $error("rx busy flag wrong");
  cnt_up_a: assert property (
    rx_only_s |=> o_stored_packet_count == $past(o_stored_packet_count) + 1'b1)
    else $error("packet count not raised");
  cnt_dn_a: assert property (
    dn_only_s |=> !o_down_valid &&
    o_stored_packet_count == $past(o_stored_packet_count) - 1'b1)
    else $error("packet count not lowered");
  dn_flow_a: assert property (
    o_down_valid && !dn_end |=> o_down_valid) else $error("down gap");
endmodule : msa_check_sva

bind msa_stream_adapter msa_check_sva i_chk (
  .i_clock(i_clock), .i_rstn(i_rstn),
  .i_switch_src0_valid(i_switch_src0_valid),
  .i_switch_src0_end(i_switch_src0_end),
  .o_switch_src0_ready(o_switch_src0_ready), .o_tx_tvalid(o_tx_tvalid),
  .i_tx_tready(i_tx_tready), .o_tx_tdata(o_tx_tdata),
  .o_tx_tlast(o_tx_tlast), .i_rx_tvalid(i_rx_tvalid),
  .o_rx_tready(o_rx_tready), .i_rx_tlast(i_rx_tlast),
  .o_down_valid(o_down_valid), .i_down_ready(i_down_ready),
  .o_down_end(o_down_end), .o_rx_in_progress(o_rx_in_progress),
  .o_stored_packet_count(o_stored_packet_count)
);

/* test/msa_mac_model.sv */
`timescale 1ns/1ps

module msa_mac_model (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_tx_hold,
  input wire logic i_down_hold,
  output logic o_tx_tready,
  output logic o_down_ready
);
  // The MAC may pause at any beat, so it accepts at random.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tx_tready <= 1'b0;
    end else begin
      o_tx_tready <= !i_tx_hold && ($urandom_range(3) != 0);
    end
  end

  // The engine pops a beat only when it shows ready.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_down_ready <= 1'b0;
    end else begin
      o_down_ready <= !i_down_hold && ($urandom_range(1) != 0);
    end
  end
endmodule : msa_mac_model

/* test/testbench.sv */
`timescale 1ns/1ps

module testbench;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic [1:0] sv = 2'b00, se = 2'b00, busy = 2'b00;
  logic [63:0] sw [2] = '{default: '0};
  logic [7:0] sk [2] = '{default: '0};
  logic rv = 1'b0, rl = 1'b0, ru = 1'b0, tx_hold = 1'b0, dn_hold = 1'b0;
  logic [63:0] rd = '0;
  logic [7:0] rk = '0;
  wire [1:0] srdy;
  wire tv, tl, rrdy, dv, de, du, prog, tx_tready, dn_ready;
  wire [63:0] td, dw;
  wire [7:0] tk, dk;
  wire [12:0] cnt;
  logic [73:0] txq [$], rxq [$];
  logic chq [$];
  int bad_count = 0, num_checks = 0, cycles = 0, mcnt = 0;

  always #5 i_clock = ~i_clock;

  msa_stream_adapter i_dut (
    .i_clock(i_clock), .i_rstn(i_rstn),
    .i_switch_src0_valid(sv[0]), .i_switch_src0_word(sw[0]),
    .i_switch_src0_byte_en(sk[0]), .i_switch_src0_end(se[0]),
    .o_switch_src0_ready(srdy[0]), .i_switch_src1_valid(sv[1]),
    .i_switch_src1_word(sw[1]), .i_switch_src1_byte_en(sk[1]),
    .i_switch_src1_end(se[1]), .o_switch_src1_ready(srdy[1]),
    .o_tx_tvalid(tv), .i_tx_tready(tx_tready), .o_tx_tdata(td),
    .o_tx_tkeep(tk), .o_tx_tlast(tl), .i_rx_tvalid(rv), .o_rx_tready(rrdy),
    .i_rx_tdata(rd), .i_rx_tkeep(rk), .i_rx_tlast(rl), .i_rx_tuser(ru),
    .o_down_valid(dv), .i_down_ready(dn_ready), .o_down_word(dw),
    .o_down_byte_en(dk), .o_down_end(de), .o_down_user_flag(du),
    .o_rx_in_progress(prog), .o_stored_packet_count(cnt)
  );

  msa_mac_model i_mac (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_tx_hold(tx_hold),
    .i_down_hold(dn_hold), .o_tx_tready(tx_tready), .o_down_ready(dn_ready)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [73:0] seen, input logic [73:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // A source holds each beat until taken and rests one cycle after the packet.
  task automatic send_pkt(input int ch, input int len);
    for (int i = 0; i < len; i++) begin
      sv[ch] <= 1'b1;
      sw[ch] <= {$urandom(), $urandom()};
      sk[ch] <= (i == len - 1) ? 8'h0F : 8'hFF;
      se[ch] <= (i == len - 1);
      do @(posedge i_clock); while (srdy[ch] !== 1'b1);
    end
    sv[ch] <= 1'b0;
    sw[ch] <= ~sw[ch];
    @(posedge i_clock);
  endtask : send_pkt

  // The MAC never waits for ready; it only pauses at random.
  task automatic rx_pkt(input int len);
    for (int i = 0; i < len; i++) begin
      if ($urandom_range(3) == 0) begin
        rv <= 1'b0;
        rd <= ~rd;
        @(posedge i_clock);
      end
      rv <= 1'b1;
      rd <= {$urandom(), $urandom()};
      rk <= 8'($urandom());
      rl <= (i == len - 1);
      ru <= 1'($urandom_range(1));
      @(posedge i_clock);
    end
  endtask : rx_pkt

  // Reference model: queues of accepted words and a packet count.
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      conclude();
    end
    if (i_rstn) begin
      check(cnt, mcnt[12:0]);
      for (int c = 0; c < 2; c++) begin
        if (sv[c] && srdy[c]) begin
          if (!busy[c]) chq.push_back(c[0]);
          busy[c] = !se[c];
          txq.push_back({1'b0, se[c], sk[c], sw[c]});
        end
      end
      if (tv && tx_tready) check({1'b0, tl, tk, td}, txq.pop_front());
      if (rv && rrdy) begin
        rxq.push_back({ru, rl, rk, rd});
        mcnt += rl;
      end
      if (dv && dn_ready) begin
        check({du, de, dk, dw}, rxq.pop_front());
        mcnt -= de;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(83));
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    // Both sources ask together from idle.
    fork
      send_pkt(0, 5);
      send_pkt(1, 6);
    join
    check(chq[0], 1'b0);
    check(chq[1], 1'b1);
    for (int n = 4; n < 9; n++) send_pkt(n % 2, n);
    // With the MAC held, the third long packet passes the input threshold.
    tx_hold <= 1'b1;
    repeat (3) send_pkt(0, 400);
    fork
      send_pkt(0, 4);
      begin
        repeat (50) @(posedge i_clock);
        check(srdy[0], 1'b0);
        tx_hold <= 1'b0;
      end
    join
    rx_pkt(1);
    rx_pkt(3);
    rx_pkt(7);
    dn_hold <= 1'b1;
    repeat (5) rx_pkt(500);
    rv <= 1'b0;
    @(posedge i_clock);
    check(rrdy, 1'b1);
    rx_pkt(500);
    rv <= 1'b0;
    @(posedge i_clock);
    check(rrdy, 1'b0);
    rx_pkt(10);
    rv <= 1'b0;
    dn_hold <= 1'b0;
    while (rxq.size() != 0 || txq.size() != 0) @(posedge i_clock);
    repeat (4) @(posedge i_clock);
    check(rrdy, 1'b1);
    conclude();
  end
endmodule : testbench
